// ===== include/poed_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Registers on 32-bit classic Wishbone, one word each
// Notes: Byte addresses; low bits carry the register data
`ifndef POED_DEFINES_SVH
`define POED_DEFINES_SVH
// ==========================================
// Register offsets
`define POED_OFS_ICTRL2 6'h00
`define POED_OFS_OSHORT2 6'h04
`define POED_OFS_ICTRL3 6'h08
`define POED_OFS_SWHIZ 6'h0C
`define POED_OFS_PINEN1 6'h10
`define POED_OFS_PINEN2 6'h14
// ==========================================
// Field positions
`define POED_ICTRL2_FLAG_LSB 12
`define POED_ICTRL_IE_BIT 8
`define POED_FLAG_BIT 12
`define POED_OSH_FLAG_BIT 15
`define POED_HIZE_BIT 9
`define POED_OSH_IE_BIT 8
`define POED_SW_SEC_BIT 2
`define POED_SW_CH0_BIT 1
`define POED_SW_CH34_BIT 0
// ==========================================
// Reset values
`define POED_PINEN1_RST 4'h0
`define POED_PINEN2_RST 6'h00
// ==========================================
// Timing: sample taps of the divided clock and run length
`define POED_DIV8_BIT 2
`define POED_DIV16_BIT 3
`define POED_DIV128_BIT 6
`define POED_LOW_RUN 16
`endif

// ===== include/poed_pkg.sv
// Purpose: Types of the output-disable block
// Assumes: Used with poed_defines.svh
// Notes: Types only
package poed_pkg;
  typedef enum logic [1:0] {
    POED_MODE_EDGE = 2'h0,
    POED_MODE_DIV8 = 2'h1,
    POED_MODE_DIV16 = 2'h2,
    POED_MODE_DIV128 = 2'h3
  } poed_mode_e;
  typedef logic [31:0] poed_word_t;
  typedef struct packed {
    logic [6:0] prescale;
    logic [4:0] pin_prev;
    logic [4:0][4:0] low_cnt;
    logic [4:0] high_seen;
    logic [4:0] flag;
    logic [4:0] flag_read;
    poed_mode_e [4:0] mode;
    logic mode2_done;
    logic mode3_done;
    logic ie2;
    logic ie3;
    logic req8_hiz_enable;
    logic short_flag_2;
    logic short_read;
    logic short_hiz_enable_2;
    logic ocse_done;
    logic short_irq_enable_2;
    logic [2:0] sw_hiz;
    logic [2:0] sw_read;
    logic [3:0] pin_en1;
    logic pin_en1_done;
    logic [5:0] pin_en2;
    logic pin_en2_done;
    logic ack;
    poed_word_t dat;
    logic irq;
    logic hiz_ch0;
    logic hiz_ch34;
    logic [5:0] hiz_sec;
  } poed_state_s;
endpackage

// ===== hdl/poed_top.sv
// Contract
// - Modes: falling edge or sixteen divided lows
// - Accepted request sets its input flag
// - Flag clears by zero after reading one
// - Sampling clear needs high sample first
// - Group two enable gates flags four-seven
// - Write-once fields take first write only
// - Both outputs of pair active sets flag
// - Short flag clears zero after one read
// - Short enable plus flag forces high impedance
// - Short enable gates short interrupt
// - Reserved bits read zero
// - Input eight uses same mode encoding
// - Input eight flag set and clear
// - Input eight enable plus flag forces hiz
// - Group three enable gates input eight
// - Secondary software bit set by one
// - Software bits clear zero after read
// - Channel zero bit forces channel zero hiz
// - Channels three-four bit forces hiz
// - Pin enables gate secondary pair hiz
// - Pin enables select channel zero hiz
// Purpose: Output-disable controller, request inputs four to eight
// Assumes: Classic Wishbone slave, one clock, synchronous inputs
// Notes: Ack is one cycle after request; ack drops the next cycle
`timescale 1ns/100ps
`include "poed_defines.svh"
module poed_top
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire poed_pkg::poed_word_t wb_dat_in,
  input wire logic [4:0] req_in_n_in,
  input wire logic [2:0] pos_out_in,
  input wire logic [2:0] neg_out_in,
  output logic wb_ack_out,
  output poed_pkg::poed_word_t wb_dat_out,
  output logic irq_out,
  output logic hiz_ch0_out,
  output logic hiz_ch34_out,
  output logic [5:0] hiz_sec_out
);
  import poed_pkg::*;
  poed_state_s r;
  poed_state_s next_r;
  logic req;
  logic wr;
  logic rd;
  logic [15:0] wdat;
  logic [4:0] tick;
  logic [4:0] accept;

  // ==========================================
  // Helpers
  function automatic logic div_tick(input poed_mode_e m, input logic [6:0] p);
    logic t;
    t = 1'b0;
    unique case (m)
      POED_MODE_EDGE: t = 1'b0;
      POED_MODE_DIV8: t = (p[`POED_DIV8_BIT:0] == 3'h0);
      POED_MODE_DIV16: t = (p[`POED_DIV16_BIT:0] == 4'h0);
      POED_MODE_DIV128: t = (p[`POED_DIV128_BIT:0] == 7'h00);
    endcase
    return t;
  endfunction

  // Hardware set wins over a clear in the same cycle
  function automatic logic flag_next(input logic f, input logic set, input logic clr);
    return set | (f & ~clr);
  endfunction

  assign req = wb_cyc_in & wb_stb_in & ~r.ack;
  assign wr = req & wb_we_in & wb_sel_in[0] & wb_sel_in[1];
  assign rd = req & ~wb_we_in;
  assign wdat = wb_dat_in[15:0];

  always_comb
  begin
    next_r = r;
    next_r.prescale = r.prescale + 7'h01;
    next_r.pin_prev = req_in_n_in;
    for (int i = 0; i < 5; i++)
    begin
      tick[i] = div_tick(r.mode[i], r.prescale);
      if (tick[i])
      begin
        if (req_in_n_in[i])
        begin
          next_r.low_cnt[i] = 5'h00;
          next_r.high_seen[i] = 1'b1;
        end
        else if (r.low_cnt[i] != 5'(`POED_LOW_RUN))
        begin
          next_r.low_cnt[i] = r.low_cnt[i] + 5'h01;
        end
      end
      if (r.mode[i] == POED_MODE_EDGE)
      begin
        accept[i] = r.pin_prev[i] & ~req_in_n_in[i];
      end
      else
      begin
        accept[i] = tick[i] & ~req_in_n_in[i] &
          (r.low_cnt[i] == 5'(`POED_LOW_RUN - 1));
      end
      if (accept[i])
      begin
        next_r.high_seen[i] = 1'b0;
      end
    end
    next_r.ack = req;
    next_r.dat = '0;
    // ==========================================
    // Register reads; reserved read zero
    if (rd)
    begin
      unique case (wb_adr_in)
        `POED_OFS_ICTRL2:
        begin
          next_r.dat[15:12] = r.flag[3:0];
          next_r.dat[`POED_ICTRL_IE_BIT] = r.ie2;
          next_r.dat[7:0] = {r.mode[3], r.mode[2], r.mode[1], r.mode[0]};
          next_r.flag_read[3:0] = r.flag[3:0];
        end
        `POED_OFS_OSHORT2:
        begin
          next_r.dat[`POED_OSH_FLAG_BIT] = r.short_flag_2;
          next_r.dat[`POED_HIZE_BIT] = r.short_hiz_enable_2;
          next_r.dat[`POED_OSH_IE_BIT] = r.short_irq_enable_2;
          next_r.short_read = r.short_flag_2;
        end
        `POED_OFS_ICTRL3:
        begin
          next_r.dat[`POED_FLAG_BIT] = r.flag[4];
          next_r.dat[`POED_HIZE_BIT] = r.req8_hiz_enable;
          next_r.dat[`POED_ICTRL_IE_BIT] = r.ie3;
          next_r.dat[1:0] = r.mode[4];
          next_r.flag_read[4] = r.flag[4];
        end
        `POED_OFS_SWHIZ:
        begin
          next_r.dat[2:0] = r.sw_hiz;
          next_r.sw_read = r.sw_hiz;
        end
        `POED_OFS_PINEN1: next_r.dat[3:0] = r.pin_en1;
        `POED_OFS_PINEN2: next_r.dat[5:0] = r.pin_en2;
        default: next_r.dat = '0;
      endcase
    end
    // ==========================================
    // Register writes
    for (int i = 0; i < 5; i++)
    begin
      // needs high sample in sampling mode
      next_r.flag[i] = flag_next(r.flag[i], accept[i],
        wr && ((i < 4) ? (wb_adr_in == `POED_OFS_ICTRL2) : (wb_adr_in == `POED_OFS_ICTRL3))
        && !wdat[(i < 4) ? (`POED_ICTRL2_FLAG_LSB + i) : `POED_FLAG_BIT]
        && r.flag_read[i]
        && (r.mode[i] == POED_MODE_EDGE || r.high_seen[i]));
      if (accept[i])
      begin
        next_r.flag[i] = 1'b1;
      end
      if (!next_r.flag[i])
      begin
        next_r.flag_read[i] = 1'b0;
      end
    end
    if (wr)
    begin
      unique case (wb_adr_in)
        `POED_OFS_ICTRL2:
        begin
          next_r.ie2 = wdat[`POED_ICTRL_IE_BIT];
          if (!r.mode2_done)
          begin
            next_r.mode2_done = 1'b1;
            for (int i = 0; i < 4; i++)
            begin
              next_r.mode[i] = poed_mode_e'(wdat[2 * i +: 2]);
            end
          end
        end
        `POED_OFS_OSHORT2:
        begin
          next_r.short_irq_enable_2 = wdat[`POED_OSH_IE_BIT];
          if (!r.ocse_done)
          begin
            next_r.ocse_done = 1'b1;
            next_r.short_hiz_enable_2 = wdat[`POED_HIZE_BIT];
          end
        end
        `POED_OFS_ICTRL3:
        begin
          next_r.ie3 = wdat[`POED_ICTRL_IE_BIT];
          if (!r.mode3_done)
          begin
            next_r.mode3_done = 1'b1;
            next_r.mode[4] = poed_mode_e'(wdat[1:0]);
            next_r.req8_hiz_enable = wdat[`POED_HIZE_BIT];
          end
        end
        `POED_OFS_SWHIZ:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (wdat[i])
            begin
              next_r.sw_hiz[i] = 1'b1;
            end
            else if (r.sw_read[i])
            begin
              next_r.sw_hiz[i] = 1'b0;
            end
          end
        end
        `POED_OFS_PINEN1:
        begin
          if (!r.pin_en1_done)
          begin
            next_r.pin_en1_done = 1'b1;
            next_r.pin_en1 = wdat[3:0];
          end
        end
        `POED_OFS_PINEN2:
        begin
          if (!r.pin_en2_done)
          begin
            next_r.pin_en2_done = 1'b1;
            next_r.pin_en2 = wdat[5:0];
          end
        end
        default: next_r.ie2 = r.ie2;
      endcase
    end
    for (int i = 0; i < 3; i++)
    begin
      if (!next_r.sw_hiz[i])
      begin
        next_r.sw_read[i] = 1'b0;
      end
    end
    next_r.short_flag_2 = flag_next(r.short_flag_2, 1'b0,
      wr && wb_adr_in == `POED_OFS_OSHORT2 && !wdat[`POED_OSH_FLAG_BIT] && r.short_read);
    if (|(pos_out_in & neg_out_in))
    begin
      next_r.short_flag_2 = 1'b1;
    end
    if (!next_r.short_flag_2)
    begin
      next_r.short_read = 1'b0;
    end
    // ==========================================
    // Outputs
    // interrupt from group two, group three and short flag
    next_r.irq = (r.ie2 & |r.flag[3:0]) | (r.short_irq_enable_2 & r.short_flag_2) |
      (r.ie3 & r.flag[4]);
    next_r.hiz_ch0 = |r.pin_en1 &
      ((r.req8_hiz_enable & r.flag[4]) | r.sw_hiz[`POED_SW_CH0_BIT]);
    next_r.hiz_ch34 = r.sw_hiz[`POED_SW_CH34_BIT];
    next_r.hiz_sec = r.pin_en2 & {6{(r.short_hiz_enable_2 & r.short_flag_2) |
      (|r.flag[3:0]) | r.sw_hiz[`POED_SW_SEC_BIT]}};
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.pin_prev <= 5'h1F;
      r.pin_en1 <= `POED_PINEN1_RST;
      r.pin_en2 <= `POED_PINEN2_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wb_ack_out = r.ack;
  assign wb_dat_out = r.dat;
  assign irq_out = r.irq;
  assign hiz_ch0_out = r.hiz_ch0;
  assign hiz_ch34_out = r.hiz_ch34;
  assign hiz_sec_out = r.hiz_sec;

  // ==========================================
  // Checks
  AST_ACK_ONE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req |=> wb_ack_out ##1 !wb_ack_out) else $error("ack not single");
  AST_EDGE_SET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.mode[0] == POED_MODE_EDGE && r.pin_prev[0] && !req_in_n_in[0]) |=> r.flag[0])
    else $error("edge lost");
  AST_NO_BLIND_CLR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.flag[0] && !r.flag_read[0]) |=> r.flag[0]) else $error("unread clear");
  AST_SAMPLE_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.flag[4] && r.mode[4] != POED_MODE_EDGE && !r.high_seen[4]) |=> r.flag[4])
    else $error("clear before high");
  AST_MODE_ONCE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    r.mode2_done |=> $stable(r.mode[0])) else $error("mode rewritten");
  AST_SHORT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    |(pos_out_in & neg_out_in) |=> r.short_flag_2) else $error("short missed");
  AST_IRQ2: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.ie2 && |r.flag[3:0]) |=> irq_out) else $error("irq missing");
  AST_SW_SET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr && wb_adr_in == `POED_OFS_SWHIZ && wdat[0]) |=> ##1 hiz_ch34_out)
    else $error("sw hiz missing");
  AST_IRQ3: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.ie3 && r.flag[4]) |=> irq_out)
    else $error("group three irq missing");
  AST_IRQ_SHORT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.short_irq_enable_2 && r.short_flag_2) |=> irq_out)
    else $error("short irq missing");
  AST_NO_IRQ: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!r.ie2 && !r.ie3 && !r.short_irq_enable_2) |=> !irq_out)
    else $error("irq while disabled");
  AST_HIZ8: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.req8_hiz_enable && r.flag[4] && |r.pin_en1) |=> hiz_ch0_out)
    else $error("input eight hiz missing");
  AST_CH0_SW: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.sw_hiz[`POED_SW_CH0_BIT] && |r.pin_en1) |=> hiz_ch0_out)
    else $error("channel zero hiz missing");
  AST_CH34_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !r.sw_hiz[`POED_SW_CH34_BIT] |=> !hiz_ch34_out)
    else $error("stray channels three-four hiz");
  AST_SHORT_HIZ: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.short_hiz_enable_2 && r.short_flag_2) |=> (hiz_sec_out == $past(r.pin_en2)))
    else $error("short hiz missing");
  AST_SEC_SW: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    r.sw_hiz[`POED_SW_SEC_BIT] |=> (hiz_sec_out == $past(r.pin_en2)))
    else $error("secondary sw hiz missing");
  AST_SEC_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.pin_en2 == 6'h00) |=> (hiz_sec_out == 6'h00))
    else $error("disabled pair in hiz");
  AST_RESERVED: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wb_ack_out |-> (wb_dat_out[31:16] == 16'h0000))
    else $error("upper read bits set");
  AST_LOW_RESTART: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (tick[4] && req_in_n_in[4]) |=> (r.low_cnt[4] == 5'h00))
    else $error("low count kept");
  AST_SHORT_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.short_flag_2 && !r.short_read) |=> r.short_flag_2)
    else $error("short flag cleared unread");
  AST_MODE3_ONCE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    r.mode3_done |=> $stable(r.mode[4]))
    else $error("input eight mode rewritten");
  AST_FLAG8_SET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    accept[4] |=> r.flag[4])
    else $error("input eight flag lost");
  AST_SW_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (r.sw_hiz[`POED_SW_SEC_BIT] && !r.sw_read[`POED_SW_SEC_BIT]) |=> r.sw_hiz[`POED_SW_SEC_BIT])
    else $error("sw bit cleared unread");
  COV_EDGE: cover property (@(posedge sys_clk_in) accept[0]);
  COV_SHORT: cover property (@(posedge sys_clk_in) r.short_flag_2 && r.short_hiz_enable_2);
  COV_SAMPLE: cover property (@(posedge sys_clk_in) accept[4] && r.mode[4] != POED_MODE_EDGE);
  COV_HIZ: cover property (@(posedge sys_clk_in) |hiz_sec_out);
endmodule

// ===== verif/poed_far_side.sv
// Purpose: Request pins and timer pair outputs
// Assumes: Bench commands lows and shorts
// Notes: Pairs toggle when idle, never both high
`timescale 1ns/100ps
module poed_far_side
(
  input wire logic sys_clk_in,
  input wire logic [4:0] low_mask_in,
  input wire logic [2:0] short_mask_in,
  output logic [4:0] req_in_n_out,
  output logic [2:0] pos_out,
  output logic [2:0] neg_out
);
  logic [2:0] phase = 3'h5;
  always_ff @(posedge sys_clk_in)
  begin
    phase <= ~phase;
  end
  assign req_in_n_out = ~low_mask_in;
  assign pos_out = phase | short_mask_in;
  assign neg_out = ~phase | short_mask_in;
endmodule

// ===== verif/poed_top_tb_top.sv
// Purpose: Self-checking bench of the output-disable block
// Assumes: Ack one cycle after request
// Notes: Random seed fixed; modes lock on first write
`timescale 1ns/100ps
`include "poed_defines.svh"
module poed_top_tb_top;
  import poed_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  poed_word_t dat = 32'h0000_0000;
  logic [4:0] low_mask = 5'h00;
  logic [2:0] short_mask = 3'h0;
  logic [4:0] req_n;
  logic [2:0] pos;
  logic [2:0] neg;
  logic ack;
  poed_word_t rdat;
  logic irq;
  logic hiz_ch0;
  logic hiz_ch34;
  logic [5:0] hiz_sec;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  int p;
  poed_word_t q;
  always #50 sys_clk = ~sys_clk;
  poed_top uut (.sys_clk_in(sys_clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .req_in_n_in(req_n), .pos_out_in(pos), .neg_out_in(neg), .wb_ack_out(ack),
    .wb_dat_out(rdat), .irq_out(irq), .hiz_ch0_out(hiz_ch0), .hiz_ch34_out(hiz_ch34),
    .hiz_sec_out(hiz_sec));
  poed_far_side far (.sys_clk_in(sys_clk), .low_mask_in(low_mask),
    .short_mask_in(short_mask), .req_in_n_out(req_n), .pos_out(pos), .neg_out(neg));
  // ==========================================
  // Report
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_reg(input poed_word_t e, input poed_word_t g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t reg exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_pin(input logic [5:0] e, input logic [5:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t pin exp %h got %h", $time, e, g);
    end
  endtask
  // ==========================================
  // Classic bus cycle, held until ack
  task automatic wb(input logic [5:0] a, input logic w, input poed_word_t d,
    output poed_word_t r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input poed_word_t d);
    poed_word_t r;
    wb(a, 1'b1, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input poed_word_t e);
    poed_word_t r;
    wb(a, 1'b0, 32'h0000_0000, r);
    chk_reg(e, r);
  endtask
  function automatic poed_word_t flag_bit(input int b);
    return 32'h0000_0001 << b;
  endfunction
  // Divider of each sampling mode code
  function automatic int div_of(input int m);
    return (m == 1) ? 8 : (m == 2) ? 16 : (m == 3) ? 128 : 0;
  endfunction
  // Hang guard, tests need under 5000 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(51104));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(6'(i * 4), 32'h0000_0000);
    k = $urandom_range(3, 0);
    p = $urandom_range(2, 0);
    wr(`POED_OFS_ICTRL2, 32'h0000_0100);
    wr(`POED_OFS_ICTRL2, 32'h0000_01FF);
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_0100);
    low_mask[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_0100 | flag_bit(12 + k));
    chk_pin(6'(1), 6'(irq));
    wr(`POED_OFS_ICTRL2, 32'h0000_F100);
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_0100 | flag_bit(12 + k));
    wr(`POED_OFS_ICTRL2, 32'h0000_0100);
    low_mask[k] <= 1'b0;
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_0100);
    chk_pin(6'(0), 6'(irq));
    wr(`POED_OFS_PINEN1, 32'h0000_000F);
    wr(`POED_OFS_ICTRL3, 32'h0000_0301);
    low_mask[4] <= 1'b1;
    repeat (100) @(posedge sys_clk);
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_0301);
    repeat (50) @(posedge sys_clk);
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_1301);
    chk_pin(6'(1), 6'(hiz_ch0));
    chk_pin(6'(1), 6'(irq));
    wr(`POED_OFS_ICTRL3, 32'h0000_0301);
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_1301);
    low_mask[4] <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_1301);
    wr(`POED_OFS_ICTRL3, 32'h0000_0301);
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_0301);
    wr(`POED_OFS_PINEN2, 32'h0000_003F);
    wr(`POED_OFS_OSHORT2, 32'h0000_0300);
    short_mask[p] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    short_mask <= 3'h0;
    repeat (3) @(posedge sys_clk);
    rd_chk(`POED_OFS_OSHORT2, 32'h0000_8300);
    chk_pin(6'h3F, hiz_sec);
    chk_pin(6'(1), 6'(irq));
    wr(`POED_OFS_OSHORT2, 32'h0000_0300);
    rd_chk(`POED_OFS_OSHORT2, 32'h0000_0300);
    chk_pin(6'h00, hiz_sec);
    wr(`POED_OFS_SWHIZ, 32'h0000_0007);
    rd_chk(`POED_OFS_SWHIZ, 32'h0000_0007);
    chk_pin(6'(1), 6'(hiz_ch34));
    chk_pin(6'(1), 6'(hiz_ch0));
    chk_pin(6'h3F, hiz_sec);
    wr(`POED_OFS_SWHIZ, 32'h0000_0000);
    rd_chk(`POED_OFS_SWHIZ, 32'h0000_0000);
    rd_chk(`POED_OFS_PINEN1, 32'h0000_000F);
    rd_chk(`POED_OFS_PINEN2, 32'h0000_003F);
    // Mid-run reset re-arms the write-once fields
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(`POED_OFS_ICTRL3, 32'h0000_0000);
    wr(`POED_OFS_ICTRL2, 32'h0000_01E4);
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_01E4);
    low_mask[k] <= 1'b1;
    if (k > 0)
    begin
      repeat (15 * div_of(k) - 5) @(posedge sys_clk);
      rd_chk(`POED_OFS_ICTRL2, 32'h0000_01E4);
    end
    repeat (div_of(k) + 8) @(posedge sys_clk);
    rd_chk(`POED_OFS_ICTRL2, 32'h0000_01E4 | flag_bit(12 + k));
    chk_pin(6'(1), 6'(irq));
    chk_pin(6'h00, hiz_sec);
    low_mask[k] <= 1'b0;
    wr(6'h1C, $urandom);
    rd_chk(6'h1C, 32'h0000_0000);
    wrap_up();
  end
endmodule
